// ==== inc/cpcia_pkg.sv ====
// package: constants, register map and types of the priority chain controller
package cpcia_pkg;
  // register byte offsets on the AXI4-Lite slave
  localparam int AXI_AW = 4;
  localparam logic [AXI_AW-1:0] CTRL_OFF = 4'h0;
  localparam logic [AXI_AW-1:0] CFG_OFF = 4'h4;
  localparam logic [AXI_AW-1:0] STAT_OFF = 4'h8;
  localparam logic [AXI_AW-1:0] RESP_OFF = 4'hc;
  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;
  // control register fields and reset values
  localparam int CTRL_HPS_BIT = 0;
  localparam int CTRL_HPI_BIT = 1;
  localparam int CTRL_EVEN_BIT = 2;
  localparam int CTRL_SWIRQ_BIT = 3;
  localparam logic [2:0] CTRL_RST = 3'h0;
  // configuration register fields
  localparam int CFG_ADDR_LSB = 0;
  localparam int CFG_PNUM_LSB = 8;
  localparam int CFG_DST_LSB = 16;
  localparam logic [31:0] CFG_RST = 32'h0;
  // status register fields above the 16 status bits
  localparam int STAT_IRQ_BIT = 16;
  localparam int STAT_CONN_BIT = 17;
  localparam int STAT_SEL_BIT = 18;
  // terminal order bits, index 0 is the first data line
  localparam int TORD_IRQ_BIT = 0;
  localparam int TORD_HALT_BIT = 3;
  // interrupt type code of standard i/o interrupts
  localparam logic [2:0] AIO_STD_TYPE = 3'h0;
  // synchroniser lanes
  localparam int SY_AVI = 0;
  localparam int SY_FS = 1;
  localparam int SY_SVC = 2;
  localparam int SY_AIO = 3;
  localparam int SY_HPS = 4;
  localparam int SY_HPI = 5;
  localparam int SY_CLM = 6;
  localparam int N_SYNC = 7;
  // response word, first field is the most significant bit (bit 0)
  typedef struct packed {
    logic [7:0] dev_status;
    logic incorrect_len;
    logic xmit_err;
    logic zero_cnt;
    logic chan_end;
    logic unusual_end;
    logic [2:0] unused;
    logic [4:0] zeros;
    logic [2:0] proc_num;
    logic [7:0] dev_addr;
  } cpcia_resp_t;
  // interrupt flags of the last command doubleword
  typedef struct packed {
    logic zero_count_irq_flag;
    logic channel_end_irq_flag;
    logic unusual_end_irq_flag;
  } cpcia_flags_t;
  // one-cycle events from the controller data path
  typedef struct packed {
    logic incorrect_len;
    logic xmit_err;
    logic chan_end;
    logic zero_count;
  } cpcia_evt_t;
  typedef enum logic [1:0] {ST_IDLE, ST_RESOLVE, ST_ACK} cpcia_state_t;
endpackage : cpcia_pkg

// ==== src/cpcia_ctrl.sv ====
// priority chain, strobe acknowledge and interrupt acknowledge logic of one controller
//
// Summary of operation
// - interrupt acknowledge answered only for interrupt type code 000.
// - acknowledge forwarded to next processor unless an interrupt is pending here.
// - selected interrupter returns address and status; processor number appended.
// - response word: status 0-7 device, 8-15 standard, zeros, processor, address.
// - bit 8 reports incorrect length, bit 9 transmission data error.
// - bit 10 set only with zero count flag and byte count zero.
// - bit 11 set only with channel end flag and channel end reported.
// - bit 12 set only with unusual end flag and halt terminal order.
// - terminal order with bit 0 true raises an interrupt request.
// - internal condition or push-button event may also raise an interrupt.
// - first controller in chain has avail_in tied true.
// - later avail_in comes from previous avail_out, point to point.
// - no pending request: assert avail_out once avail_in seen.
// - pending low priority request passes avail when high priority line true.
// - pending request driving high priority, or line false, claims instead.
// - passive strobe acknowledge in each of the three chain outcomes.
// - claimer connects for service; others wait for later acknowledge.
// - interrupt acknowledge uses same chain with interrupt priority line.
// - only one interrupter answers; others keep their requests.
// - priority and claim lines are wired buses, sensed and driven.
// - strobe with service acknowledge function goes to all controllers.
// - on strobe release leading acknowledge and drive trailing acknowledge.
// - after strobe drops drive leading again and release trailing.
// - selected controller puts its address on response lines.
`timescale 1ns/100ps
module cpcia_ctrl (
  // clock and reset
  input wire logic CLOCK_I,
  input wire logic RESET_I,
  // axi4-lite slave
  input wire logic [cpcia_pkg::AXI_AW-1:0] S_AXI_AWADDR_I,
  input wire logic S_AXI_AWVALID_I,
  output logic S_AXI_AWREADY_O,
  input wire logic [31:0] S_AXI_WDATA_I,
  input wire logic [3:0] S_AXI_WSTRB_I,
  input wire logic S_AXI_WVALID_I,
  output logic S_AXI_WREADY_O,
  output logic [1:0] S_AXI_BRESP_O,
  output logic S_AXI_BVALID_O,
  input wire logic S_AXI_BREADY_I,
  input wire logic [cpcia_pkg::AXI_AW-1:0] S_AXI_ARADDR_I,
  input wire logic S_AXI_ARVALID_I,
  output logic S_AXI_ARREADY_O,
  output logic [31:0] S_AXI_RDATA_O,
  output logic [1:0] S_AXI_RRESP_O,
  output logic S_AXI_RVALID_O,
  input wire logic S_AXI_RREADY_I,
  // processor bus, asynchronous
  input wire logic FUNCTION_STROBE_I,
  input wire logic SVC_ACK_FN_I,
  input wire logic IRQ_ACK_FN_I,
  input wire logic [2:0] IRQ_TYPE_I,
  output logic STROBE_ACK_LEADING_O,
  output logic STROBE_ACK_LEADING_OE_O,
  output logic STROBE_ACK_TRAILING_O,
  output logic STROBE_ACK_TRAILING_OE_O,
  output logic [7:0] FUNCTION_RESPONSE_O,
  output logic FUNCTION_RESPONSE_OE_O,
  output logic [15:0] IRQ_STATUS_O,
  output logic IRQ_ACK_FWD_O,
  // priority cable, asynchronous
  input wire logic AVAIL_IN_I,
  output logic AVAIL_OUT_O,
  input wire logic HIGH_PRIO_SERVICE_I,
  output logic HIGH_PRIO_SERVICE_O,
  output logic HIGH_PRIO_SERVICE_OE_O,
  input wire logic HIGH_PRIO_INTERRUPT_I,
  output logic HIGH_PRIO_INTERRUPT_O,
  output logic HIGH_PRIO_INTERRUPT_OE_O,
  input wire logic CHAIN_CLAIM_I,
  output logic CHAIN_CLAIM_O,
  output logic CHAIN_CLAIM_OE_O,
  // controller data path, synchronous
  input wire logic SVC_REQ_I,
  input wire logic TORD_VALID_I,
  input wire logic [0:7] TORD_DATA_I,
  input wire cpcia_pkg::cpcia_flags_t FLAGS_I,
  input wire cpcia_pkg::cpcia_evt_t EVT_I,
  input wire logic INT_EVENT_I,
  output logic CONNECTED_O
);
  import cpcia_pkg::*;

  // byte-lane merge of a register write
  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction : wmerge

  logic [N_SYNC-1:0] sync1;
  logic [N_SYNC-1:0] sync2;
  logic fs_d;
  logic [2:0] ctrl;
  logic [31:0] cfg;
  cpcia_resp_t resp;
  logic irq_pend;
  logic sel;
  logic is_aio;
  logic drive_level;
  cpcia_state_t st;
  logic aw_hold;
  logic w_hold;
  logic [AXI_AW-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic [4:0] std_bits;

  // the raw lanes, packed for one synchroniser bank
  wire [N_SYNC-1:0] raw_in = {CHAIN_CLAIM_I, HIGH_PRIO_INTERRUPT_I, HIGH_PRIO_SERVICE_I,
                              IRQ_ACK_FN_I, SVC_ACK_FN_I, FUNCTION_STROBE_I, AVAIL_IN_I};

  // two-flop synchronisers; only sync2 is looked at
  always_ff @(posedge CLOCK_I or posedge RESET_I) begin
    if (RESET_I) begin
      sync1 <= '0;
      sync2 <= '0;
    end else begin
      sync1 <= raw_in;
      sync2 <= sync1;
    end
  end

  // synchronised views; avail_in is tied true on the first unit and
  // wired from the upstream avail_out elsewhere, so it is never a bus
  wire avi_s = sync2[SY_AVI];
  wire fs_s = sync2[SY_FS];
  wire svc_s = sync2[SY_SVC];
  wire aio_s = sync2[SY_AIO];
  wire hps_s = sync2[SY_HPS];
  wire hpi_s = sync2[SY_HPI];
  wire clm_s = sync2[SY_CLM];
  wire fs_rise = fs_s && !fs_d;

  // chain selection terms; interrupt acknowledge swaps in its own line
  wire type_ok = (IRQ_TYPE_I == AIO_STD_TYPE);
  wire pend = is_aio ? (irq_pend && type_ok) : SVC_REQ_I;
  wire hp_s = is_aio ? hpi_s : hps_s;
  wire own_hp = is_aio ? HIGH_PRIO_INTERRUPT_OE_O : HIGH_PRIO_SERVICE_OE_O;
  wire pass_ok = !pend || (hp_s && !own_hp);
  wire do_pass = (st == ST_RESOLVE) && avi_s && pass_ok;
  wire do_claim = (st == ST_RESOLVE) && avi_s && !pass_ok;
  wire seen_clm = (st == ST_RESOLVE) && clm_s && !CHAIN_CLAIM_OE_O;
  wire resolved = do_pass || do_claim || seen_clm;
  wire aio_win = do_claim && is_aio;

  // register bus decode
  wire do_wr = aw_hold && w_hold && !S_AXI_BVALID_O;
  wire wr_ctrl = do_wr && (aw_addr == CTRL_OFF);
  wire wr_cfg = do_wr && (aw_addr == CFG_OFF);
  wire wr_ok = (aw_addr == CTRL_OFF) || (aw_addr == CFG_OFF) || (aw_addr == STAT_OFF) ||
               (aw_addr == RESP_OFF);
  wire [31:0] ctrl_nw = wmerge({29'h0, ctrl}, w_data, w_strb);
  wire sw_irq = wr_ctrl && w_strb[0] && w_data[CTRL_SWIRQ_BIT];
  wire ar_hs = S_AXI_ARVALID_I && S_AXI_ARREADY_O;
  wire rd_ok = (S_AXI_ARADDR_I == CTRL_OFF) || (S_AXI_ARADDR_I == CFG_OFF) ||
               (S_AXI_ARADDR_I == STAT_OFF) || (S_AXI_ARADDR_I == RESP_OFF);

  // live standard status bits, set by data path events
  wire [4:0] std_set = {EVT_I.incorrect_len,
                        EVT_I.xmit_err,
                        FLAGS_I.zero_count_irq_flag && EVT_I.zero_count,
                        FLAGS_I.channel_end_irq_flag && EVT_I.chan_end,
                        FLAGS_I.unusual_end_irq_flag && TORD_VALID_I &&
                        TORD_DATA_I[TORD_HALT_BIT]};
  wire [15:0] stat16 = {cfg[CFG_DST_LSB +: 8], std_bits, 3'h0};
  wire [31:0] stat_rd = {13'h0, sel, CONNECTED_O, irq_pend, stat16};
  wire [31:0] rd_mux = (S_AXI_ARADDR_I == CTRL_OFF) ? {29'h0, ctrl} :
                       (S_AXI_ARADDR_I == CFG_OFF) ? cfg :
                       (S_AXI_ARADDR_I == STAT_OFF) ? stat_rd :
                       (S_AXI_ARADDR_I == RESP_OFF) ? resp : 32'h0;

  // interrupt sources: terminal order bit, software or enabled push-button
  wire irq_src = (TORD_VALID_I && TORD_DATA_I[TORD_IRQ_BIT]) ||
                 sw_irq || (ctrl[CTRL_EVEN_BIT] && INT_EVENT_I);
  // a new source in the acknowledge cycle wins over the clear
  wire next_irq_pend = irq_src || (irq_pend && !aio_win);
  wire [4:0] next_std = std_set | (aio_win ? 5'h0 : std_bits);

  // write channel: address and data taken in either order
  always_ff @(posedge CLOCK_I or posedge RESET_I) begin
    if (RESET_I) begin
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      aw_addr <= '0;
      w_data <= 32'h0;
      w_strb <= 4'h0;
      S_AXI_AWREADY_O <= 1'b1;
      S_AXI_WREADY_O <= 1'b1;
      S_AXI_BVALID_O <= 1'b0;
      S_AXI_BRESP_O <= AXI_OKAY;
    end else begin
      if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
        aw_hold <= 1'b1;
        aw_addr <= S_AXI_AWADDR_I;
        S_AXI_AWREADY_O <= 1'b0;
      end
      if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
        w_hold <= 1'b1;
        w_data <= S_AXI_WDATA_I;
        w_strb <= S_AXI_WSTRB_I;
        S_AXI_WREADY_O <= 1'b0;
      end
      if (do_wr) begin
        aw_hold <= 1'b0;
        w_hold <= 1'b0;
        S_AXI_BVALID_O <= 1'b1;
        S_AXI_BRESP_O <= wr_ok ? AXI_OKAY : AXI_SLVERR;
      end else if (S_AXI_BVALID_O && S_AXI_BREADY_I) begin
        S_AXI_BVALID_O <= 1'b0;
        S_AXI_AWREADY_O <= 1'b1;
        S_AXI_WREADY_O <= 1'b1;
      end
    end
  end

  // read channel: one read at a time, answer one cycle after the address
  always_ff @(posedge CLOCK_I or posedge RESET_I) begin
    if (RESET_I) begin
      S_AXI_ARREADY_O <= 1'b1;
      S_AXI_RVALID_O <= 1'b0;
      S_AXI_RDATA_O <= 32'h0;
      S_AXI_RRESP_O <= AXI_OKAY;
    end else if (ar_hs) begin
      S_AXI_ARREADY_O <= 1'b0;
      S_AXI_RVALID_O <= 1'b1;
      S_AXI_RDATA_O <= rd_mux;
      S_AXI_RRESP_O <= rd_ok ? AXI_OKAY : AXI_SLVERR;
    end else if (S_AXI_RVALID_O && S_AXI_RREADY_I) begin
      S_AXI_RVALID_O <= 1'b0;
      S_AXI_ARREADY_O <= 1'b1;
    end
  end

  // software registers and sticky interrupt state
  always_ff @(posedge CLOCK_I or posedge RESET_I) begin
    if (RESET_I) begin
      ctrl <= CTRL_RST;
      cfg <= CFG_RST;
      irq_pend <= 1'b0;
      std_bits <= 5'h0;
    end else begin
      if (wr_ctrl) begin
        ctrl <= ctrl_nw[2:0];
      end
      if (wr_cfg) begin
        cfg <= wmerge(cfg, w_data, w_strb);
      end
      irq_pend <= next_irq_pend;
      std_bits <= next_std;
    end
  end

  // chain and strobe handshake; every strobe is acknowledged, so an
  // unaddressed unit never hangs the processor
  always_ff @(posedge CLOCK_I or posedge RESET_I) begin
    if (RESET_I) begin
      st <= ST_IDLE;
      fs_d <= 1'b0;
      is_aio <= 1'b0;
      sel <= 1'b0;
      drive_level <= 1'b0;
      AVAIL_OUT_O <= 1'b0;
      CHAIN_CLAIM_OE_O <= 1'b0;
      STROBE_ACK_LEADING_OE_O <= 1'b0;
      STROBE_ACK_TRAILING_OE_O <= 1'b0;
      FUNCTION_RESPONSE_O <= 8'h0;
      FUNCTION_RESPONSE_OE_O <= 1'b0;
      IRQ_STATUS_O <= 16'h0;
      resp <= '0;
    end else begin
      fs_d <= fs_s;
      drive_level <= 1'b1;
      case (st)
        ST_IDLE: begin
          STROBE_ACK_LEADING_OE_O <= 1'b1;
          if (fs_rise) begin
            is_aio <= aio_s;
            st <= (svc_s || aio_s) ? ST_RESOLVE : ST_ACK;
          end
        end
        ST_RESOLVE: begin
          if (do_pass) begin
            AVAIL_OUT_O <= 1'b1;
          end
          if (do_claim) begin
            CHAIN_CLAIM_OE_O <= 1'b1;
            sel <= 1'b1;
            FUNCTION_RESPONSE_O <= cfg[CFG_ADDR_LSB +: 8];
            FUNCTION_RESPONSE_OE_O <= 1'b1;
          end
          if (aio_win) begin
            IRQ_STATUS_O <= stat16;
            resp <= '{dev_status: cfg[CFG_DST_LSB +: 8], incorrect_len: std_bits[4],
                      xmit_err: std_bits[3], zero_cnt: std_bits[2], chan_end: std_bits[1],
                      unusual_end: std_bits[0], unused: 3'h0, zeros: 5'h0,
                      proc_num: cfg[CFG_PNUM_LSB +: 3],
                      dev_addr: cfg[CFG_ADDR_LSB +: 8]};
          end
          if (resolved) begin
            STROBE_ACK_LEADING_OE_O <= 1'b0;
            STROBE_ACK_TRAILING_OE_O <= 1'b1;
            st <= ST_ACK;
          end
        end
        ST_ACK: begin
          STROBE_ACK_LEADING_OE_O <= 1'b0;
          STROBE_ACK_TRAILING_OE_O <= 1'b1;
          if (!fs_s) begin
            STROBE_ACK_LEADING_OE_O <= 1'b1;
            STROBE_ACK_TRAILING_OE_O <= 1'b0;
            AVAIL_OUT_O <= 1'b0;
            CHAIN_CLAIM_OE_O <= 1'b0;
            FUNCTION_RESPONSE_OE_O <= 1'b0;
            sel <= 1'b0;
            st <= ST_IDLE;
          end
        end
        default: st <= ST_IDLE;
      endcase
    end
  end

  // wired lines: value is true from the first clock after reset, the enable carries the drive;
  // connection is held until the data path drops its service request
  always_ff @(posedge CLOCK_I or posedge RESET_I) begin
    if (RESET_I) begin
      HIGH_PRIO_SERVICE_OE_O <= 1'b0;
      HIGH_PRIO_INTERRUPT_OE_O <= 1'b0;
      IRQ_ACK_FWD_O <= 1'b0;
      CONNECTED_O <= 1'b0;
    end else begin
      HIGH_PRIO_SERVICE_OE_O <= SVC_REQ_I && ctrl[CTRL_HPS_BIT];
      HIGH_PRIO_INTERRUPT_OE_O <= irq_pend && ctrl[CTRL_HPI_BIT];
      IRQ_ACK_FWD_O <= aio_s && !irq_pend;
      if (do_claim && !is_aio) begin
        CONNECTED_O <= 1'b1;
      end else if (!SVC_REQ_I) begin
        CONNECTED_O <= 1'b0;
      end
    end
  end

  assign HIGH_PRIO_SERVICE_O = drive_level;
  assign HIGH_PRIO_INTERRUPT_O = drive_level;
  assign CHAIN_CLAIM_O = drive_level;
  assign STROBE_ACK_LEADING_O = drive_level;
  assign STROBE_ACK_TRAILING_O = drive_level;

  // checks beside the logic they guard
  a_no_pend_pass: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
    (st == ST_RESOLVE && !pend && avi_s) |=> AVAIL_OUT_O && !CHAIN_CLAIM_OE_O)
    else $error("idle unit did not pass avail");
  a_low_prio_pass: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
    (st == ST_RESOLVE && pend && avi_s && hp_s && !own_hp) |=> AVAIL_OUT_O)
    else $error("low priority requester did not pass avail");
  a_claim_instead: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
    (st == ST_RESOLVE && pend && avi_s && (own_hp || !hp_s)) |=>
    CHAIN_CLAIM_OE_O && !AVAIL_OUT_O && FUNCTION_RESPONSE_OE_O)
    else $error("requester did not claim");
  a_ack_lead_rel: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
    $rose(st == ST_ACK) |-> ##1 (!STROBE_ACK_LEADING_OE_O && STROBE_ACK_TRAILING_OE_O))
    else $error("strobe not acknowledged");
  a_ack_trail_rel: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
    (st == ST_ACK && !fs_s) |=> STROBE_ACK_LEADING_OE_O && !STROBE_ACK_TRAILING_OE_O)
    else $error("strobe release not acknowledged");
  a_resp_addr: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
    $rose(CHAIN_CLAIM_OE_O) |-> FUNCTION_RESPONSE_O == $past(cfg[7:0]))
    else $error("response lines do not carry own address");
  a_irq_raise: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
    (TORD_VALID_I && TORD_DATA_I[TORD_IRQ_BIT]) |=> irq_pend)
    else $error("terminal order interrupt lost");
  a_zero_cnt: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
    $rose(std_bits[2]) |-> $past(FLAGS_I.zero_count_irq_flag && EVT_I.zero_count))
    else $error("zero count bit set without cause");
  a_irq_type: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
    (st == ST_RESOLVE && is_aio && !type_ok) |=> !CHAIN_CLAIM_OE_O)
    else $error("claimed a non-standard interrupt type");
endmodule : cpcia_ctrl

// ==== tb/cpcia_far_model.sv ====
// far-side model: neighbour controllers and the wired priority cable
`timescale 1ns/100ps
module cpcia_far_model (
  // drive of the unit under test
  input wire logic dut_hps_i,
  input wire logic dut_hps_oe_i,
  input wire logic dut_hpi_i,
  input wire logic dut_hpi_oe_i,
  input wire logic dut_clm_i,
  input wire logic dut_clm_oe_i,
  // neighbours and the unit above
  input wire logic nb_hps_i,
  input wire logic nb_hpi_i,
  input wire logic nb_clm_i,
  input wire logic up_avail_i,
  // levels seen by the unit under test
  output logic hps_o,
  output logic hpi_o,
  output logic clm_o,
  output logic avail_o
);
  // wired-or lines; a released line falls to its pull-down level
  assign hps_o = nb_hps_i | (dut_hps_oe_i & dut_hps_i);
  assign hpi_o = nb_hpi_i | (dut_hpi_oe_i & dut_hpi_i);
  assign clm_o = nb_clm_i | (dut_clm_oe_i & dut_clm_i);
  // point to point from the unit above, held true for the head unit
  assign avail_o = up_avail_i;
endmodule : cpcia_far_model

// ==== tb/controller_priority_chain_irq_ack_test.sv ====
// self-checking bench of one chain controller
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin mismatches++; \
  $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
module controller_priority_chain_irq_ack_test import cpcia_pkg::*;;
  logic clk = 1'b0, rst = 1'b1;
  logic [3:0] awaddr = '0, araddr = '0, wstrb = 4'hf;
  logic [31:0] wdata = '0, d;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic strobe = 0, svc_ack = 0, irq_ack = 0, svc_req = 0, tord_v = 0, int_ev = 0;
  logic nb_hps = 0, nb_hpi = 0, nb_clm = 0, up_av = 1'b1;
  logic [2:0] irq_type = '0;
  logic [0:7] tord_d = '0;
  logic [1:0] r;
  cpcia_flags_t flags = '0;
  cpcia_evt_t evt = '0;
  wire awready, wready, bvalid, arready, rvalid, lead, lead_oe, trail, trail_oe, resp_oe, fwd;
  wire avail_out, hps_o, hps_oe, hpi_o, hpi_oe, clm_o, clm_oe, conn, hps_l, hpi_l, clm_l, av_l;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [7:0] resp;
  wire [15:0] irq_stat;
  int mismatches = 0, n_compared = 0;
  // free-running 100 MHz clock
  always #5 clk = ~clk;
  cpcia_ctrl u_cpcia_ctrl (.CLOCK_I(clk), .RESET_I(rst), .S_AXI_AWADDR_I(awaddr),
    .S_AXI_AWVALID_I(awvalid), .S_AXI_AWREADY_O(awready), .S_AXI_WDATA_I(wdata),
    .S_AXI_WSTRB_I(wstrb), .S_AXI_WVALID_I(wvalid), .S_AXI_WREADY_O(wready),
    .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(bready),
    .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid), .S_AXI_ARREADY_O(arready),
    .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rvalid),
    .S_AXI_RREADY_I(rready), .FUNCTION_STROBE_I(strobe), .SVC_ACK_FN_I(svc_ack),
    .IRQ_ACK_FN_I(irq_ack), .IRQ_TYPE_I(irq_type), .STROBE_ACK_LEADING_O(lead),
    .STROBE_ACK_LEADING_OE_O(lead_oe), .STROBE_ACK_TRAILING_O(trail),
    .STROBE_ACK_TRAILING_OE_O(trail_oe), .FUNCTION_RESPONSE_O(resp),
    .FUNCTION_RESPONSE_OE_O(resp_oe), .IRQ_STATUS_O(irq_stat), .IRQ_ACK_FWD_O(fwd),
    .AVAIL_IN_I(av_l), .AVAIL_OUT_O(avail_out), .HIGH_PRIO_SERVICE_I(hps_l),
    .HIGH_PRIO_SERVICE_O(hps_o), .HIGH_PRIO_SERVICE_OE_O(hps_oe),
    .HIGH_PRIO_INTERRUPT_I(hpi_l), .HIGH_PRIO_INTERRUPT_O(hpi_o),
    .HIGH_PRIO_INTERRUPT_OE_O(hpi_oe), .CHAIN_CLAIM_I(clm_l), .CHAIN_CLAIM_O(clm_o),
    .CHAIN_CLAIM_OE_O(clm_oe), .SVC_REQ_I(svc_req), .TORD_VALID_I(tord_v),
    .TORD_DATA_I(tord_d), .FLAGS_I(flags), .EVT_I(evt), .INT_EVENT_I(int_ev),
    .CONNECTED_O(conn));
  cpcia_far_model u_cpcia_far_model (.dut_hps_i(hps_o), .dut_hps_oe_i(hps_oe),
    .dut_hpi_i(hpi_o), .dut_hpi_oe_i(hpi_oe), .dut_clm_i(clm_o), .dut_clm_oe_i(clm_oe),
    .nb_hps_i(nb_hps), .nb_hpi_i(nb_hpi), .nb_clm_i(nb_clm), .up_avail_i(up_av),
    .hps_o(hps_l), .hpi_o(hpi_l), .clm_o(clm_l), .avail_o(av_l));
  // verdict and end of run
  task wrap_up;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : wrap_up
  // a bounded wait ran out
  task tmo(input string w);
    mismatches++;
    $display("MISMATCH timeout %s exp 1 got 0", w);
    wrap_up();
  endtask : tmo
  // write: both channels offered together, bready held until the answer
  task wr(input logic [3:0] a, input logic [31:0] dv, input logic [1:0] er);
    int n;
    @(posedge clk);
    awaddr <= a;
    wdata <= dv;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    if (n == 40) tmo("b");
    `CHK("bresp", er, bresp)
  endtask : wr
  // read: rready held until rvalid is sampled
  task rd(input logic [3:0] a);
    int n;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    if (n == 40) tmo("r");
  endtask : rd
  // wait until the leading drive enable reaches a level, sampled at edges
  task wait_lead(input logic v);
    int n;
    for (n = 0; n < 40 && lead_oe !== v; n++) @(posedge clk);
    if (n == 40) tmo("ack");
  endtask : wait_lead
  // strobe with function indicators, to every unit at once
  task fn_on(input logic s, input logic i, input logic [2:0] t);
    @(posedge clk);
    svc_ack <= s;
    irq_ack <= i;
    irq_type <= t;
    strobe <= 1'b1;
    wait_lead(1'b0);
  endtask : fn_on
  // strobe release; acknowledge, claim and avail outputs settle back to idle
  task fn_off;
    @(posedge clk);
    strobe <= 1'b0;
    svc_ack <= 1'b0;
    irq_ack <= 1'b0;
    wait_lead(1'b1);
    `CHK("trail_idle", 1'b0, trail_oe)
    `CHK("claim_idle", 1'b0, clm_oe)
    `CHK("avail_idle", 1'b0, avail_out)
  endtask : fn_off
  // registers: reset value, read-back, a misaligned address
  task t_regs;
    rd(CTRL_OFF);
    `CHK("ctrl_rst", 32'h0, d)
    wr(CFG_OFF, 32'h00a5035a, AXI_OKAY);
    rd(CFG_OFF);
    `CHK("cfg", 32'h00a5035a, d)
    wr(4'h2, 32'hffffffff, AXI_SLVERR);
    rd(4'h2);
    `CHK("unmapped", {AXI_SLVERR, 32'h0}, {r, d})
    $display("test regs done");
  endtask : t_regs
  // idle unit passes avail and acknowledges passively
  task t_pass;
    fn_on(1'b1, 1'b0, 3'h0);
    `CHK("avail", 1'b1, avail_out)
    `CHK("trail", 1'b1, trail_oe)
    `CHK("claim", 1'b0, clm_oe)
    fn_off();
    // a strobe for some other instruction is only acknowledged passively
    fn_on(1'b0, 1'b0, 3'h0);
    `CHK("other_ack", {1'b1, 1'b0, 1'b0}, {trail_oe, avail_out, clm_oe})
    fn_off();
    $display("test pass done");
  endtask : t_pass
  // pending request with no high-priority line claims and connects
  task t_claim;
    svc_req <= 1'b1;
    fn_on(1'b1, 1'b0, 3'h0);
    `CHK("claim", {1'b1, 1'b0}, {clm_oe, avail_out})
    `CHK("resp", {1'b1, 8'h5a}, {resp_oe, resp})
    rd(STAT_OFF);
    `CHK("sel_stat", 2'b11, d[STAT_SEL_BIT -: 2])
    fn_off();
    `CHK("conn", 1'b1, conn)
    svc_req <= 1'b0;
    repeat (3) @(posedge clk);
    `CHK("conn_end", 1'b0, conn)
    $display("test claim done");
  endtask : t_claim
  // low-priority request yields to another unit, own drive claims
  task t_prio;
    svc_req <= 1'b1;
    nb_hps <= 1'b1;
    fn_on(1'b1, 1'b0, 3'h0);
    `CHK("low_pass", {1'b1, 1'b0}, {avail_out, clm_oe})
    fn_off();
    wr(CTRL_OFF, 32'h1, AXI_OKAY);
    repeat (2) @(posedge clk);
    `CHK("hps_drive", 1'b1, hps_oe & hps_o)
    fn_on(1'b1, 1'b0, 3'h0);
    `CHK("own_claim", {1'b0, 1'b1}, {avail_out, clm_oe})
    fn_off();
    wr(CTRL_OFF, 32'h0, AXI_OKAY);
    svc_req <= 1'b0;
    nb_hps <= 1'b0;
    $display("test prio done");
  endtask : t_prio
  // another unit claims; this one only acknowledges
  task t_busy;
    up_av <= 1'b0;
    nb_clm <= 1'b1;
    fn_on(1'b1, 1'b0, 3'h0);
    `CHK("busy_ack", {1'b1, 1'b0, 1'b0}, {trail_oe, avail_out, clm_oe})
    fn_off();
    up_av <= 1'b1;
    nb_clm <= 1'b0;
    $display("test busy done");
  endtask : t_busy
  // interrupt raised by events and orders, then acknowledged
  task t_irq;
    flags <= 3'b111;
    @(posedge clk);
    evt <= 4'b1011;
    tord_v <= 1'b1;
    tord_d <= 8'b1001_0000;
    @(posedge clk);
    evt <= 4'b0000;
    tord_v <= 1'b0;
    rd(STAT_OFF);
    `CHK("irq_set", 1'b1, d[STAT_IRQ_BIT])
    `CHK("std_bits", 16'ha5b8, d[15:0])
    fn_on(1'b0, 1'b1, 3'h1);
    `CHK("type_skip", {1'b1, 1'b0, 1'b0}, {avail_out, clm_oe, fwd})
    fn_off();
    // the service priority line must not sway an interrupt acknowledge
    nb_hps <= 1'b1;
    fn_on(1'b0, 1'b1, AIO_STD_TYPE);
    `CHK("irq_win", {1'b1, 1'b1, 8'h5a}, {clm_oe, resp_oe, resp})
    fn_off();
    nb_hps <= 1'b0;
    `CHK("irq_stat", 16'ha5b8, irq_stat)
    rd(RESP_OFF);
    `CHK("resp_word", 32'ha5b8035a, d)
    rd(STAT_OFF);
    `CHK("irq_clr", 1'b0, d[STAT_IRQ_BIT])
    flags <= '0;
    evt <= 4'b0011;
    @(posedge clk);
    evt <= 4'b0000;
    rd(STAT_OFF);
    `CHK("flag_gate", 5'h0, d[7:3])
    fn_on(1'b0, 1'b1, AIO_STD_TYPE);
    `CHK("fwd", {1'b1, 1'b1}, {fwd, avail_out})
    fn_off();
    wr(CTRL_OFF, 32'h6, AXI_OKAY);
    @(posedge clk);
    int_ev <= 1'b1;
    @(posedge clk);
    int_ev <= 1'b0;
    rd(STAT_OFF);
    `CHK("int_event", 1'b1, d[STAT_IRQ_BIT])
    `CHK("hpi_drive", 1'b1, hpi_oe & hpi_o)
    up_av <= 1'b0;
    nb_clm <= 1'b1;
    fn_on(1'b0, 1'b1, AIO_STD_TYPE);
    `CHK("irq_lose", 1'b0, clm_oe)
    fn_off();
    rd(STAT_OFF);
    `CHK("irq_kept", 1'b1, d[STAT_IRQ_BIT])
    $display("test irq done");
  endtask : t_irq
  // main sequence: reset for ten cycles, then the scenarios
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    `CHK("idle_lead", 1'b1, lead_oe)
    `CHK("idle_lvl", 4'hf, {lead, trail, clm_o, hpi_o})
    t_regs();
    t_pass();
    t_claim();
    t_prio();
    t_busy();
    t_irq();
    wrap_up();
  end
endmodule : controller_priority_chain_irq_ack_test
